// >>> ddrcs_byte_lane.sv
// One byte lane: data, mask and its own strobe, with read-side synchronisers.
`timescale 1ns/1ps
module ddrcs_byte_lane (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       drive,
  input  wire logic       take,
  input  wire logic [7:0] wr_byte,
  input  wire logic       wr_dm,
  input  wire logic [7:0] dq_i,
  input  wire logic       dqs_i,
  output logic      [7:0] dq_o,
  output logic            dq_oe,
  output logic            dqs_o,
  output logic            dqs_oe,
  output logic            dm,
  output logic      [7:0] rd_byte,
  output logic            dqs_seen
);

  typedef struct packed {
    logic [7:0] dq;
    logic       dqoe;
    logic       dm;
    logic       dqs;
    logic       dqsoe;
    logic [7:0] q1;
    logic [7:0] q2;
    logic       s1;
    logic       s2;
  } ddrcs_lane_s;

  ddrcs_lane_s r;
  ddrcs_lane_s n;

  always_comb begin
    n = r;
    // Strobe is driven from the WRITE command edge onward, parked low until data runs.
    n.dqsoe = drive;
    n.dqs   = take ? ~r.dqs : 1'b0;
    n.dqoe  = take;
    if (take) begin
      n.dq = wr_byte;
      n.dm = wr_dm;
    end
    n.q1 = dq_i;
    n.q2 = r.q1;
    n.s1 = dqs_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dq_o     = r.dq;
  assign dq_oe    = r.dqoe;
  assign dqs_o    = r.dqs;
  assign dqs_oe   = r.dqsoe;
  assign dm       = r.dm;
  assign rd_byte  = r.q2;
  assign dqs_seen = r.s2;

endmodule

// >>> ddrcs_ctrl.sv
// Controller that spaces DDR module commands and schedules refresh and self refresh.
`timescale 1ns/1ps
module ddrcs_ctrl
  import ddrcs_pkg::*;
#(
  parameter int LANES            = 9,
  parameter int BURST_CLKS       = 2,
  parameter int WRITE_LAT_CLKS   = 2,
  parameter int RD_LAT_CLKS      = 4,
  parameter int MAX_REF_GAP_CLKS = REFC_CLKS
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                req_valid,
  input  wire logic [2:0]          req_op,
  input  wire logic [1:0]          req_bank,
  input  wire logic [ADDR_W-1:0]   req_addr,
  output logic                     req_ready,
  input  wire logic [LANES*8-1:0]  wr_data,
  input  wire logic [LANES-1:0]    wr_mask,
  output logic                     wr_take,
  output logic      [LANES*8-1:0]  rd_data,
  output logic                     rd_valid,
  output logic      [LANES-1:0]    rd_strobe_seen,
  output logic      [3:0]          ref_deficit,
  output logic                     in_self_refresh,
  output logic                     ddr_cke,
  output logic                     ddr_cs_n,
  output logic                     ddr_ras_n,
  output logic                     ddr_cas_n,
  output logic                     ddr_we_n,
  output logic      [1:0]          ddr_ba,
  output logic      [ADDR_W-1:0]   ddr_addr,
  output logic      [LANES*8-1:0]  ddr_dq_o,
  output logic      [LANES*8-1:0]  ddr_dq_oe,
  input  wire logic [LANES*8-1:0]  ddr_dq_i,
  output logic      [LANES-1:0]    ddr_dqs_o,
  output logic      [LANES-1:0]    ddr_dqs_oe,
  input  wire logic [LANES-1:0]    ddr_dqs_i,
  output logic      [LANES-1:0]    ddr_dm
);

  // ==========================================================================
  // Local widths
  localparam int GAP_W = $clog2(MAX_REF_GAP_CLKS + 1);
  localparam int WC_W  = $clog2(WRITE_LAT_CLKS + BURST_CLKS + 1);
  localparam int RC_W  = $clog2(RD_LAT_CLKS + BURST_CLKS + 3);
  localparam logic [GAP_W-1:0] GAP_MAX   = GAP_W'(MAX_REF_GAP_CLKS);
  localparam logic [GAP_W-1:0] GAP_FORCE = GAP_W'(MAX_REF_GAP_CLKS - FORCE_MARGIN);
  localparam logic [WC_W-1:0]  WC_LOAD   = WC_W'(WRITE_LAT_CLKS + BURST_CLKS);
  localparam logic [WC_W-1:0]  WC_BURST  = WC_W'(BURST_CLKS);
  localparam logic [RC_W-1:0]  RC_LOAD   = RC_W'(RD_LAT_CLKS + BURST_CLKS + 2);
  localparam logic [RC_W-1:0]  RC_BURST  = RC_W'(BURST_CLKS);
  localparam logic [REFI_W-1:0] TICK_END = REFI_W'(REFI_CLKS - 1);

  // ==========================================================================
  // State
  typedef struct packed {
    ddrcs_st_e         st;
    logic              pend_sr;
    logic [3:0]        deficit;
    logic [GAP_W-1:0]  gap;
    logic [REFI_W-1:0] tick;
    logic [WC_W-1:0]   wcnt;
    logic [RC_W-1:0]   rcnt;
    logic              cke;
    logic [3:0]        cmd;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
  } ddrcs_ctl_s;

  ddrcs_ctl_s        r;
  ddrcs_ctl_s        n;
  logic [T_N-1:0]    t_start;
  logic [T_N-1:0]    busy;
  logic              tick;
  logic              ref_go;
  logic              need_ref;
  logic              force_ref;
  logic              ref_ok;
  logic              rdy;
  logic              wr_go;
  logic [ADDR_W-1:0] all_banks;
  logic [LANES-1:0]  lane_dq_oe;

  // ==========================================================================
  // Spacing timers
  ddrcs_gap_timer #(
    .CHANS (T_N),
    .W     (TMR_W)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (t_start),
    .load     ({LD_XSR, LD_XSN, LD_RFC, LD_RP, LD_WR, LD_WTR, LD_ACT}),
    .busy     (busy)
  );

  // ==========================================================================
  // Refresh demand
  always_comb begin
    tick      = (r.st != ST_SREF) && (r.tick == TICK_END);
    need_ref  = (r.deficit != 4'h0);
    // Forcing one short of the limit leaves room for a tick during the precharge.
    force_ref = (r.deficit >= POST_LIMIT - 4'h1) || (r.gap >= GAP_FORCE);
    // A refresh is never started inside another one's busy period or write recovery.
    ref_ok    = (r.wcnt == '0) && !busy[T_WR] && !busy[T_RFC] && !busy[T_XSN];
    all_banks = '0;
    all_banks[ALL_BANKS_BIT] = 1'b1;
  end

  // ==========================================================================
  // Command sequencing
  always_comb begin
    n       = r;
    rdy     = 1'b0;
    wr_go   = 1'b0;
    ref_go  = 1'b0;
    t_start = '0;
    n.cmd   = CMD_NOP;
    n.tick  = (r.tick == TICK_END) ? '0 : r.tick + REFI_W'(1);
    n.gap   = (r.gap == GAP_MAX) ? r.gap : r.gap + GAP_W'(1);
    if (r.wcnt != '0) begin
      n.wcnt = r.wcnt - WC_W'(1);
    end
    if (r.rcnt != '0) begin
      n.rcnt = r.rcnt - RC_W'(1);
    end
    if (r.wcnt == WC_W'(1)) begin
      t_start[T_WTR] = 1'b1;
      t_start[T_WR]  = 1'b1;
    end
    case (r.st)
      ST_RUN: begin
        if (ref_ok && (force_ref || (need_ref && !req_valid))) begin
          n.cmd         = CMD_PRE;
          n.addr        = all_banks;
          n.pend_sr     = 1'b0;
          t_start[T_RP] = 1'b1;
          n.st          = ST_PREA;
        end else if (req_valid && !force_ref) begin
          case (req_op)
            OP_ACT: begin
              rdy = !busy[T_ACT] && !busy[T_RP] && !busy[T_RFC] && !busy[T_XSN];
              if (rdy) begin
                n.cmd          = CMD_ACT;
                t_start[T_ACT] = 1'b1;
              end
            end
            OP_READ: begin
              rdy = !busy[T_WTR] && !busy[T_XSR] && !busy[T_RFC] && (r.wcnt == '0);
              if (rdy) begin
                n.cmd  = CMD_READ;
                n.rcnt = RC_LOAD;
              end
            end
            OP_WRITE: begin
              rdy = !busy[T_RFC] && !busy[T_XSN] && (r.wcnt == '0);
              if (rdy) begin
                n.cmd  = CMD_WRITE;
                n.wcnt = WC_LOAD;
                wr_go  = 1'b1;
              end
            end
            OP_PRE: begin
              rdy = !busy[T_WR] && !busy[T_RFC] && !busy[T_XSN] && (r.wcnt == '0);
              if (rdy) begin
                n.cmd         = CMD_PRE;
                t_start[T_RP] = 1'b1;
              end
            end
            OP_MRS: begin
              rdy = !busy[T_RP] && !busy[T_RFC] && !busy[T_XSN];
              if (rdy) begin
                n.cmd = CMD_MRS;
              end
            end
            OP_SR_IN: begin
              rdy = ref_ok;
              if (rdy) begin
                n.cmd         = CMD_PRE;
                n.addr        = all_banks;
                n.pend_sr     = 1'b1;
                t_start[T_RP] = 1'b1;
                n.st          = ST_PREA;
              end
            end
            default: begin
              rdy = 1'b0;
            end
          endcase
          if (rdy && (req_op != OP_SR_IN)) begin
            n.ba   = req_bank;
            n.addr = req_addr;
          end
        end
      end
      ST_PREA: begin
        if (!busy[T_RP]) begin
          n.st = ST_REF;
        end
      end
      ST_REF: begin
        n.cmd = CMD_REF;
        // Clock enable only falls for self refresh entry, never inside a refresh.
        n.cke = !r.pend_sr;
        if (r.pend_sr) begin
          n.st = ST_SREF;
        end else begin
          ref_go         = 1'b1;
          t_start[T_RFC] = 1'b1;
          n.st           = ST_RUN;
        end
      end
      ST_SREF: begin
        n.gap     = '0;
        n.tick    = '0;
        n.deficit = 4'h0;
        if (req_valid && (req_op == OP_SR_EX)) begin
          rdy            = 1'b1;
          n.cke          = 1'b1;
          n.pend_sr      = 1'b0;
          t_start[T_XSN] = 1'b1;
          t_start[T_XSR] = 1'b1;
          n.st           = ST_RUN;
        end
      end
      default: begin
        n.st = ST_RUN;
      end
    endcase
    if (ref_go) begin
      n.gap = '0;
    end
    if (r.st != ST_SREF) begin
      if (tick && !ref_go && (r.deficit != POST_LIMIT)) begin
        n.deficit = r.deficit + 4'h1;
      end else if (!tick && ref_go && (r.deficit != 4'h0)) begin
        n.deficit = r.deficit - 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r      <= '0;
      r.st   <= ST_RUN;
      r.cke  <= 1'b1;
      r.cmd  <= CMD_NOP;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Byte lanes, each with a strobe of its own
  assign wr_take = (r.wcnt != '0) && (r.wcnt <= WC_BURST);

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    ddrcs_byte_lane u_lane (
      .core_clk (core_clk),
      .rstn     (rstn),
      .drive    (wr_go || (r.wcnt != '0)),
      .take     (wr_take),
      .wr_byte  (wr_data[g*8 +: 8]),
      .wr_dm    (wr_mask[g]),
      .dq_i     (ddr_dq_i[g*8 +: 8]),
      .dqs_i    (ddr_dqs_i[g]),
      .dq_o     (ddr_dq_o[g*8 +: 8]),
      .dq_oe    (lane_dq_oe[g]),
      .dqs_o    (ddr_dqs_o[g]),
      .dqs_oe   (ddr_dqs_oe[g]),
      .dm       (ddr_dm[g]),
      .rd_byte  (rd_data[g*8 +: 8]),
      .dqs_seen (rd_strobe_seen[g])
    );
    assign ddr_dq_oe[g*8 +: 8] = {8{lane_dq_oe[g]}};
  end

  // ==========================================================================
  // Outputs
  assign req_ready       = rdy;
  assign rd_valid        = (r.rcnt != '0) && (r.rcnt <= RC_BURST);
  assign ref_deficit     = r.deficit;
  assign in_self_refresh = (r.st == ST_SREF);
  assign ddr_cke         = r.cke;
  assign ddr_cs_n        = r.cmd[3];
  assign ddr_ras_n       = r.cmd[2];
  assign ddr_cas_n       = r.cmd[1];
  assign ddr_we_n        = r.cmd[0];
  assign ddr_ba          = r.ba;
  assign ddr_addr        = r.addr;

endmodule

// >>> ddrcs_ctrl_chk.sv
// Checker of the command spacing and refresh rules at the controller pins.
`timescale 1ns/1ps
module ddrcs_ctrl_chk
  import ddrcs_pkg::*;
#(
  parameter int LANES            = 9,
  parameter int MAX_REF_GAP_CLKS = REFC_CLKS
) (
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire logic [3:0]         ref_deficit,
  input wire logic               in_self_refresh,
  input wire logic               ddr_cke,
  input wire logic               ddr_cs_n,
  input wire logic               ddr_ras_n,
  input wire logic               ddr_cas_n,
  input wire logic               ddr_we_n,
  input wire logic [LANES*8-1:0] ddr_dq_oe,
  input wire logic [LANES-1:0]   ddr_dqs_oe
);
  // ==========================================================================
  // Helper logic
  logic [3:0]  cmd;
  logic [8:0]  xs_cnt_r;
  logic [15:0] gap_r;
  logic        lane_ok;

  assign cmd = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};

  always_comb begin
    lane_ok = 1'b1;
    for (int g = 0; g < LANES; g++) begin
      if (|ddr_dq_oe[g*8 +: 8] && !ddr_dqs_oe[g]) begin
        lane_ok = 1'b0;
      end
    end
  end

  // Counting from the first high clock enable keeps the exit waits exact.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      xs_cnt_r <= 9'h1ff;
      gap_r    <= 16'h0000;
    end else begin
      xs_cnt_r <= !ddr_cke ? 9'h000 : xs_cnt_r + {8'h00, xs_cnt_r != 9'h1ff};
      gap_r    <= (!ddr_cke || cmd == CMD_REF) ? 16'h0000 : gap_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_only_nop;
    (cmd == CMD_NOP) [*8];
  endsequence

  sequence s_cke_high;
    ddr_cke [*8];
  endsequence

  chk_act_gap: assert property (
    cmd == CMD_ACT |=> (cmd != CMD_ACT) [*2]) else $error("ACT spacing short");
  chk_wr_turn: assert property (
    ddr_dq_oe[0] |-> (cmd != CMD_READ) ##1 (cmd != CMD_READ)) else $error("READ after write early");
  chk_ref_quiet: assert property (
    cmd == CMD_REF |=> s_only_nop) else $error("command in refresh busy time");
  chk_ref_cke: assert property (
    cmd == CMD_REF && ddr_cke |=> s_cke_high) else $error("clock enable dropped in refresh");
  chk_xs_read: assert property (
    cmd == CMD_READ |-> xs_cnt_r >= 9'h0c8) else $error("READ early after self refresh");
  chk_xs_other: assert property (
    cmd != CMD_NOP && cmd != CMD_READ |-> xs_cnt_r >= 9'h008) else $error("command early after exit");
  chk_ref_gap: assert property (
    gap_r < 16'(MAX_REF_GAP_CLKS)) else $error("refresh gap too long");
  chk_deficit_cap: assert property (
    ref_deficit <= 4'h8) else $error("more than eight refreshes owed");
  chk_force_ref: assert property (
    $rose(ref_deficit >= 4'h7) && !in_self_refresh |-> ##[0:40] cmd == CMD_REF)
    else $error("owed refresh not forced");
  chk_strobe_early: assert property (
    cmd == CMD_WRITE |-> &ddr_dqs_oe) else $error("strobe not driven at WRITE");
  chk_lane_strobe: assert property (
    lane_ok) else $error("lane data without its strobe");
endmodule

// >>> ddrcs_ctrl_tb.sv
// Self-checking bench for the DDR command spacing and refresh controller.
`timescale 1ns/1ps
module ddrcs_ctrl_tb;
  import ddrcs_pkg::*;
  // ==========================================================================
  // Signals
  localparam int LN = 2;
  localparam int LW = LN * 8;
  logic              core_clk, rstn, req_valid, req_ready, wr_take, rd_valid, in_sr;
  logic              cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]        req_op;
  logic [1:0]        req_bank, ba;
  logic [ADDR_W-1:0] req_addr, addr;
  logic [LW-1:0]     wr_data, rd_data, dq_o, dq_oe, dq_i, exp_word;
  logic [LN-1:0]     wr_mask, strobe_seen, dqs_o, dqs_oe, dqs_i, dm;
  logic [3:0]        ref_deficit;
  logic [3:0]        cmd;
  int                fail_count, checks, refs, rd_seen, rd_asked, act_since, rd_since, since, r0;

  assign cmd = {cs_n, ras_n, cas_n, we_n};

  ddrcs_ctrl #(.LANES(LN)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req_op(req_op),
    .req_bank(req_bank), .req_addr(req_addr), .req_ready(req_ready), .wr_data(wr_data),
    .wr_mask(wr_mask), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_strobe_seen(strobe_seen), .ref_deficit(ref_deficit), .in_self_refresh(in_sr),
    .ddr_cke(cke), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n), .ddr_cas_n(cas_n), .ddr_we_n(we_n),
    .ddr_ba(ba), .ddr_addr(addr), .ddr_dq_o(dq_o), .ddr_dq_oe(dq_oe), .ddr_dq_i(dq_i),
    .ddr_dqs_o(dqs_o), .ddr_dqs_oe(dqs_oe), .ddr_dqs_i(dqs_i), .ddr_dm(dm));

  ddrcs_dimm_model #(.LANES(LN)) u_mem (
    .core_clk(core_clk), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n), .ddr_cas_n(cas_n),
    .ddr_we_n(we_n), .ddr_dq_o(dq_o), .ddr_dq_oe(dq_oe), .ddr_dqs_oe(dqs_oe), .ddr_dm(dm),
    .ddr_dq_i(dq_i), .ddr_dqs_i(dqs_i));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Pin monitor
  always @(posedge core_clk) begin
    if (cmd == CMD_REF && cke) refs++;
    if (cmd == CMD_ACT) act_since = since;
    if (cmd == CMD_READ) rd_since = since;
    since = cke ? since + 1 : 0;
    if (rd_valid === 1'b1) begin
      rd_seen++;
      check(rd_data === exp_word && strobe_seen === {LN{~rd_seen[0]}}, "read differs");
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  function automatic logic [LW-1:0] merge(input logic [LW-1:0] o, input logic [LW-1:0] n,
                                          input logic [LN-1:0] m);
    for (int g = 0; g < LN; g++) begin
      if (!m[g]) o[g*8 +: 8] = n[g*8 +: 8];
    end
    return o;
  endfunction

  task automatic idle(input int n);
    @(negedge core_clk);
    req_valid = 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  // The request stays up until the edge that takes it, or lim edges pass.
  task automatic req(input logic [2:0] op, input logic [1:0] bk, input int lim, output bit took);
    int n;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_op    = op;
    req_bank  = bk;
    req_addr  = ADDR_W'($urandom);
    if (op == OP_WRITE) begin
      wr_data  = LW'($urandom);
      wr_mask  = ($urandom % 4 == 0) ? LN'($urandom) : '0;
      exp_word = merge(exp_word, wr_data, wr_mask);
    end
    n    = 0;
    took = 1'b0;
    while (!took && n < lim) begin
      @(posedge core_clk);
      took = (req_ready === 1'b1);
      n++;
    end
  endtask

  // Write data must not move while a burst is still taking it, hence the pause.
  task automatic issue(input logic [2:0] op, input logic [1:0] bk);
    bit t;
    if (op == OP_WRITE || op == OP_READ) idle(8);
    req(op, bk, 3000, t);
    check(t, "request not taken");
    if (op == OP_READ) rd_asked++;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    bit t;
    void'($urandom(32'h4ef27718));
    {rstn, req_valid, req_op, req_bank, req_addr, wr_data, wr_mask} = '0;
    exp_word = '0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    check(cke === 1'b1 && cmd === CMD_NOP && ref_deficit === 4'h0 && in_sr === 1'b0, "reset");
    done("reset");
    issue(OP_ACT, 2'h0);
    issue(OP_ACT, 2'h1);
    issue(OP_WRITE, 2'h1);
    issue(OP_READ, 2'h1);
    for (int i = 0; i < 40; i++) issue(3'($urandom % 5), 2'($urandom));
    idle(12);
    check(rd_seen == 2 * rd_asked, "read beats missing");
    done("random traffic");
    r0 = refs;
    idle(2000);
    check(refs - r0 >= 2000 / REFI_CLKS, "too few idle refreshes");
    check(ref_deficit <= 4'h1, "refresh owed when idle");
    done("idle refresh");
    r0 = refs;
    for (int i = 0; i < 4000 && refs == r0; i++) issue(i[0] ? OP_PRE : OP_ACT, 2'(i));
    check(refs > r0, "owed refresh not forced");
    check(ref_deficit <= 4'h7, "refresh deficit too high");
    done("forced refresh");
    issue(OP_SR_IN, 2'h0);
    idle(40);
    check(in_sr === 1'b1 && cke === 1'b0, "self refresh not entered");
    req(OP_ACT, 2'h0, 20, t);
    check(!t, "request taken in self refresh");
    issue(OP_SR_EX, 2'h0);
    issue(OP_ACT, 2'h2);
    issue(OP_READ, 2'h2);
    idle(12);
    check(act_since >= 8, "ACT early after exit");
    check(rd_since >= 200, "READ early after exit");
    check(rd_seen == 2 * rd_asked, "read beats missing");
    done("self refresh");
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end
endmodule

bind ddrcs_ctrl ddrcs_ctrl_chk #(.LANES(LANES), .MAX_REF_GAP_CLKS(MAX_REF_GAP_CLKS)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .ref_deficit(ref_deficit),
  .in_self_refresh(in_self_refresh), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n),
  .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n),
  .ddr_dq_oe(ddr_dq_oe), .ddr_dqs_oe(ddr_dqs_oe));

// >>> ddrcs_dimm_model.sv
// Behavioural DDR module that keeps written lanes and answers reads.
`timescale 1ns/1ps
module ddrcs_dimm_model
  import ddrcs_pkg::*;
#(
  parameter int LANES  = 9,
  parameter int RD_LAT = 4,
  parameter int BURST  = 2
) (
  input  wire logic               core_clk,
  input  wire logic               ddr_cs_n,
  input  wire logic               ddr_ras_n,
  input  wire logic               ddr_cas_n,
  input  wire logic               ddr_we_n,
  input  wire logic [LANES*8-1:0] ddr_dq_o,
  input  wire logic [LANES*8-1:0] ddr_dq_oe,
  input  wire logic [LANES-1:0]   ddr_dqs_oe,
  input  wire logic [LANES-1:0]   ddr_dm,
  output logic      [LANES*8-1:0] ddr_dq_i,
  output logic      [LANES-1:0]   ddr_dqs_i
);
  // ==========================================================================
  // Storage and read timing
  logic [LANES*8-1:0] word_r;
  int                 since_rd;

  initial begin
    word_r    = '0;
    since_rd  = 99;
    ddr_dq_i  = '1;
    ddr_dqs_i = '0;
  end

  // Outside the read window the bus shows the inverse, since a released line keeps nothing.
  always @(posedge core_clk) begin
    since_rd <= ({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == CMD_READ) ? 1 : since_rd + 1;
    if (since_rd >= RD_LAT - 2 && since_rd <= RD_LAT + BURST - 1) begin
      ddr_dqs_i <= ~ddr_dqs_i;
      ddr_dq_i  <= word_r;
    end else begin
      ddr_dqs_i <= '0;
      ddr_dq_i  <= ~word_r;
    end
    for (int g = 0; g < LANES; g++) begin
      if (ddr_dqs_oe[g] && ddr_dq_oe[g*8] && !ddr_dm[g]) begin
        word_r[g*8 +: 8] <= ddr_dq_o[g*8 +: 8];
      end
    end
  end
endmodule

// >>> ddrcs_gap_timer.sv
// Bank of down-counting spacing timers, one channel per timing constraint.
`timescale 1ns/1ps
module ddrcs_gap_timer
  import ddrcs_pkg::*;
#(
  parameter int CHANS = T_N,
  parameter int W     = TMR_W
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic [CHANS-1:0]   start,
  input  wire logic [CHANS*W-1:0] load,
  output logic      [CHANS-1:0]   busy
);

  typedef struct packed {
    logic [CHANS-1:0][W-1:0] cnt;
  } ddrcs_tmr_s;

  ddrcs_tmr_s r;
  ddrcs_tmr_s n;

  always_comb begin
    n = r;
    for (int i = 0; i < CHANS; i++) begin
      if (start[i]) begin
        n.cnt[i] = load[i*W +: W];
      end else if (r.cnt[i] != '0) begin
        n.cnt[i] = r.cnt[i] - W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      busy[i] = (r.cnt[i] != '0);
    end
  end

endmodule

// >>> ddrcs_pkg.sv
// Constants, timing counts and encodings for the DDR command spacing and refresh controller.
// What this block does
// - Keep ACTIVE to ACTIVE on another bank at least 15 ns apart.
// - Wait at least one clock after last write data before a READ.
// - Keep average AUTO REFRESH spacing at or below 7.8 us.
// - Never let more than 70.3 us pass between two AUTO REFRESH commands.
// - Refresh every row within each 64 ms; the 7.8 us spacing is shorter and sets the average rate.
// - Never post or burst more than eight refresh cycles.
// - After self refresh exit wait 75 ns (80 ns slowest) before non-READ.
// - After self refresh exit wait 200 clocks before any READ.
// - Drive the data strobe to a valid level by the WRITE command edge.
// - Every eight-bit byte lane has its own data strobe.
// - After AUTO REFRESH issue only NOP or DESELECT for 75 ns.
// - Hold clock enable high for the whole executing refresh.
package ddrcs_pkg;

  // ==========================================================================
  // Clock and conversion
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int  REG_PATH_CLKS = 1;

  function automatic int ns_up(input real t_ns);
    return int'($ceil(t_ns / CLK_PERIOD_NS)) + REG_PATH_CLKS;
  endfunction

  // ==========================================================================
  // Minimum times, in their printed units
  localparam real ACT_TO_ACT_OTHER_BANK_GAP_NS      = 15.0;
  localparam int  WRITE_TO_READ_TURNAROUND_CK       = 1;
  localparam real WRITE_RECOVERY_NS                 = 15.0;
  localparam real PRECHARGE_PERIOD_NS               = 20.0;
  localparam real REFRESH_BUSY_PERIOD_NS            = 75.0;
  localparam real SELF_REFRESH_EXIT_NONREAD_WAIT_NS = 80.0;
  localparam int  SELF_REFRESH_EXIT_READ_WAIT_CK    = 200;

  // Slowest grade figure is used so one build serves every module.
  localparam int ACT_GAP_CLKS = ns_up(ACT_TO_ACT_OTHER_BANK_GAP_NS);
  localparam int WTR_CLKS     = WRITE_TO_READ_TURNAROUND_CK + REG_PATH_CLKS;
  localparam int WR_CLKS      = ns_up(WRITE_RECOVERY_NS);
  localparam int RP_CLKS      = ns_up(PRECHARGE_PERIOD_NS);
  localparam int RFC_CLKS     = ns_up(REFRESH_BUSY_PERIOD_NS);
  localparam int XSNR_CLKS    = ns_up(SELF_REFRESH_EXIT_NONREAD_WAIT_NS);
  localparam int XSRD_CLKS    = SELF_REFRESH_EXIT_READ_WAIT_CK + REG_PATH_CLKS;

  // ==========================================================================
  // Refresh limits, longest times round down
  localparam real AVERAGE_REFRESH_SPACING_US     = 7.8;
  localparam real MAX_REFRESH_TO_REFRESH_GAP_US  = 70.3;
  localparam real RETENTION_MS                   = 64.0;
  localparam real REFRESH_ROWS                   = 8192.0;
  localparam real RETENTION_SPACING_NS = RETENTION_MS * 1.0e6 / REFRESH_ROWS;
  localparam real AVG_SPACING_NS = (AVERAGE_REFRESH_SPACING_US * 1.0e3 < RETENTION_SPACING_NS)
                                 ? AVERAGE_REFRESH_SPACING_US * 1.0e3 : RETENTION_SPACING_NS;
  localparam int  REFI_CLKS = int'($floor(AVG_SPACING_NS / CLK_PERIOD_NS));
  localparam int  REFC_CLKS = int'($floor(MAX_REFRESH_TO_REFRESH_GAP_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int  REFI_W    = $clog2(REFI_CLKS);
  localparam logic [3:0] POST_LIMIT   = 4'h8;
  localparam int         FORCE_MARGIN = RP_CLKS + 8;

  // ==========================================================================
  // Timer channels and their loads (a load of L keeps the channel busy L cycles)
  localparam int TMR_W = 8;
  localparam int T_ACT = 0;
  localparam int T_WTR = 1;
  localparam int T_WR  = 2;
  localparam int T_RP  = 3;
  localparam int T_RFC = 4;
  localparam int T_XSN = 5;
  localparam int T_XSR = 6;
  localparam int T_N   = 7;
  localparam logic [TMR_W-1:0] LD_ACT = TMR_W'(ACT_GAP_CLKS - 1);
  localparam logic [TMR_W-1:0] LD_WTR = TMR_W'(WTR_CLKS - 1);
  localparam logic [TMR_W-1:0] LD_WR  = TMR_W'(WR_CLKS - 1);
  localparam logic [TMR_W-1:0] LD_RP  = TMR_W'(RP_CLKS - 1);
  localparam logic [TMR_W-1:0] LD_RFC = TMR_W'(RFC_CLKS - 1);
  localparam logic [TMR_W-1:0] LD_XSN = TMR_W'(XSNR_CLKS - 1);
  localparam logic [TMR_W-1:0] LD_XSR = TMR_W'(XSRD_CLKS - 1);

  // ==========================================================================
  // Command pins {cs_n, ras_n, cas_n, we_n} and request codes
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam int         ADDR_W    = 13;
  localparam int         ALL_BANKS_BIT = 10;

  typedef enum logic [2:0] {
    OP_ACT   = 3'h0,
    OP_READ  = 3'h1,
    OP_WRITE = 3'h2,
    OP_PRE   = 3'h3,
    OP_MRS   = 3'h4,
    OP_SR_IN = 3'h5,
    OP_SR_EX = 3'h6
  } ddrcs_op_e;

  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_PREA = 4'b0010,
    ST_REF  = 4'b0100,
    ST_SREF = 4'b1000
  } ddrcs_st_e;

endpackage
